/* rtl/async_serial_transmitter.sv */
// Asynchronous serial transmitter with APB register access
// Summary of operation
// - Sends only when on, async, port enabled
// - Port enable drives transmit pin as output
// - Enabling transmitter sets buffer-empty flag
// - Holding write loads idle shifter on the next cycle
// - Queued character loads right after stop bit
// - Start, data, stop follow each load
// - Polarity bit inverts idle and data levels
// - Flag set while active unless busy with character queued
// - Flag updates second cycle after write
// - Flag is read-only, hardware driven only
// - Interrupt needs flag and three enables
// - Shifter-empty status clear while shifting
// - Nine-bit mode sends ninth bit as MSB
// - Ninth bit set marks an address character
// - Low start, data, high stop, idle high
// - LSB first, no parity generated
`default_nettype none
`include "uart_tx_defs.svh"
module async_serial_transmitter (
    input  wire logic        CLOCK,
    input  wire logic        RESET_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             TX_OUT,
    output logic             TX_OE,
    output logic             TX_IRQ
);
    // ****************
    // State
    // ****************
    uart_tx_pkg::tx_regs_t r;
    uart_tx_pkg::tx_regs_t n;

    logic        active;
    logic [15:0] div_sel;
    logic [23:0] mult;
    logic [23:0] period_m1;
    logic        bit_end;
    logic        load;
    logic        wr;
    logic        mapped;
    logic        hold_acc;
    logic [7:0]  rd;
    logic [3:0]  last_bit;

    // ****************
    // Next state
    // ****************
    always_comb begin
        n = r;
        active = r.tx_ctl[`TS_TRANSMITTER_ON] & ~r.tx_ctl[`TS_SYNC_MODE]
                 & r.rx_ctl[`RS_PORT_ON];
        div_sel = r.baud_ctl[`BC_WIDE_DIVISOR] ? {r.div_hi, r.div_lo}
                                               : {8'h00, r.div_lo};
        case ({r.baud_ctl[`BC_WIDE_DIVISOR], r.tx_ctl[`TS_HIGH_SPEED]})
            2'b00:   mult = `MULT_SLOW;
            2'b11:   mult = `MULT_FAST;
            default: mult = `MULT_MID;
        endcase
        period_m1 = 24'(({8'h00, div_sel} + 24'd1) * mult) - 24'd1;
        bit_end = (r.baud_cnt == period_m1);
        last_bit = r.tx_ctl[`TS_NINE_BIT] ? `LAST_BIT_NINE : `LAST_BIT_EIGHT;
        load = 1'b0;

        // Shifter
        if (!active) begin
            n.st = uart_tx_pkg::ST_IDLE;
            n.hold_full = 1'b0;
            n.line = 1'b1;
            n.baud_cnt = 24'h000000;
        end else begin
            n.baud_cnt = bit_end ? 24'h000000 : r.baud_cnt + 24'h000001;
            case (r.st)
                uart_tx_pkg::ST_IDLE: begin
                    n.line = 1'b1;
                    n.baud_cnt = 24'h000000;
                    if (r.hold_full) begin
                        load = 1'b1;
                        n.shift = {r.hold9, r.hold};
                        n.hold_full = 1'b0;
                        n.st = uart_tx_pkg::ST_START;
                        n.line = 1'b0;
                    end
                end
                uart_tx_pkg::ST_START: begin
                    if (bit_end) begin
                        n.st = uart_tx_pkg::ST_DATA;
                        n.bit_cnt = 4'h0;
                        n.line = r.shift[0];
                    end
                end
                uart_tx_pkg::ST_DATA: begin
                    if (bit_end) begin
                        if (r.bit_cnt == last_bit) begin
                            n.st = uart_tx_pkg::ST_STOP;
                            n.line = 1'b1;
                        end else begin
                            n.shift = {1'b0, r.shift[8:1]};
                            n.bit_cnt = r.bit_cnt + 4'h1;
                            n.line = r.shift[1];
                        end
                    end
                end
                uart_tx_pkg::ST_STOP: begin
                    // Back to idle so a queued character loads next cycle
                    if (bit_end) begin
                        n.st = uart_tx_pkg::ST_IDLE;
                    end
                end
                default: begin
                    n.st = uart_tx_pkg::ST_IDLE;
                end
            endcase
        end

        // Register bus
        wr = PSEL & PENABLE & PWRITE;
        case (PADDR)
            `OFS_BAUD_CONTROL:   mapped = 1'b1;
            `OFS_RX_STATUS_CTRL: mapped = 1'b1;
            `OFS_DIVISOR_LOW:    mapped = 1'b1;
            `OFS_DIVISOR_HIGH:   mapped = 1'b1;
            `OFS_TX_HOLDING:     mapped = 1'b1;
            `OFS_TX_STATUS_CTRL: mapped = 1'b1;
            `OFS_IRQ_CONTROL:    mapped = 1'b1;
            default:             mapped = 1'b0;
        endcase
        case (PADDR)
            `OFS_BAUD_CONTROL:   rd = r.baud_ctl;
            `OFS_RX_STATUS_CTRL: rd = r.rx_ctl;
            `OFS_DIVISOR_LOW:    rd = r.div_lo;
            `OFS_DIVISOR_HIGH:   rd = r.div_hi;
            `OFS_TX_STATUS_CTRL: rd = r.tx_ctl |
                {6'h00, r.st == uart_tx_pkg::ST_IDLE, 1'b0};
            `OFS_IRQ_CONTROL:    rd = r.irq_ctl | {3'h0, r.flag, 4'h0};
            default:             rd = 8'h00;
        endcase
        if (PSEL & ~PENABLE) begin
            n.prdata = {24'h000000, rd};
        end
        hold_acc = wr & (PADDR == `OFS_TX_HOLDING) & active & (~r.hold_full | load);
        if (wr) begin
            case (PADDR)
                `OFS_BAUD_CONTROL:   n.baud_ctl = PWDATA[7:0];
                `OFS_RX_STATUS_CTRL: n.rx_ctl = PWDATA[7:0];
                `OFS_DIVISOR_LOW:    n.div_lo = PWDATA[7:0];
                `OFS_DIVISOR_HIGH:   n.div_hi = PWDATA[7:0];
                `OFS_TX_STATUS_CTRL: n.tx_ctl = PWDATA[7:0] & ~(8'h01 << `TS_SHIFTER_EMPTY);
                `OFS_IRQ_CONTROL:    n.irq_ctl = PWDATA[7:0] & `IC_WRITE_MASK;
                default: begin
                end
            endcase
        end
        if (hold_acc) begin
            n.hold = PWDATA[7:0];
            n.hold9 = r.tx_ctl[`TS_NINTH_DATA];
            n.hold_full = 1'b1;
        end

        // Flag lags the holding state by one register stage
        n.flag = active
                 & ~(r.hold_full & (r.st != uart_tx_pkg::ST_IDLE));
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            r <= '{baud_ctl: `REG_RESET, rx_ctl: `REG_RESET, div_lo: `REG_RESET,
                   div_hi: `REG_RESET, tx_ctl: `REG_RESET, irq_ctl: `REG_RESET,
                   hold: 8'h00, hold9: 1'b0, hold_full: 1'b0,
                   st: uart_tx_pkg::ST_IDLE, shift: 9'h000, bit_cnt: 4'h0,
                   baud_cnt: 24'h000000, flag: 1'b0, line: 1'b1,
                   prdata: 32'h00000000};
        end else begin
            r <= n;
        end
    end

    // ****************
    // Outputs
    // ****************
    assign PRDATA = r.prdata;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped;
    assign TX_OUT = r.line ^ r.baud_ctl[`BC_POLARITY_INVERT];
    assign TX_OE = r.rx_ctl[`RS_PORT_ON];
    assign TX_IRQ = r.flag & r.irq_ctl[`IC_TX_IRQ_ON] & r.irq_ctl[`IC_PERIPH_IRQ_ON]
                    & r.irq_ctl[`IC_GLOBAL_IRQ_ON];

    // ****************
    // Checks
    // ****************
    sequence s_stop_done;
        r.st == uart_tx_pkg::ST_STOP && bit_end && r.hold_full && active;
    endsequence
    sequence s_reload;
        r.st == uart_tx_pkg::ST_IDLE ##1 r.st == uart_tx_pkg::ST_START && !r.line;
    endsequence
    sequence s_start_end;
        r.st == uart_tx_pkg::ST_START && bit_end && active;
    endsequence
    sequence s_data_entry;
        r.st == uart_tx_pkg::ST_DATA && r.bit_cnt == 4'h0 && r.line == r.shift[0];
    endsequence
    sequence s_queued;
        r.hold_full && r.st != uart_tx_pkg::ST_IDLE && active;
    endsequence
    sequence s_full_write;
        wr && PADDR == `OFS_TX_HOLDING && r.hold_full && !load;
    endsequence

    a_pin_drive: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        r.rx_ctl[`RS_PORT_ON] |-> TX_OE)
        else $error("Transmit pin not driven with port on");
    a_off_idle: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        !active |=> r.line && r.st == uart_tx_pkg::ST_IDLE)
        else $error("Line not idle while transmitter off");
    a_enable_flag: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        $rose(active) |=> r.flag)
        else $error("Flag not set after enable");
    a_flag_delay: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        hold_acc && r.st != uart_tx_pkg::ST_IDLE && !(r.st == uart_tx_pkg::ST_STOP && bit_end)
        |-> ##1 r.flag ##1 !r.flag)
        else $error("Flag not cleared in second cycle");
    a_load_start: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        load |=> r.st == uart_tx_pkg::ST_START && !r.line && r.hold_full == $past(hold_acc))
        else $error("Load did not start a frame");
    a_stop_reload: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        s_stop_done |=> s_reload)
        else $error("Queued character not loaded after stop");
    a_empty_status: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        load |=> (r.st != uart_tx_pkg::ST_IDLE) [*4])
        else $error("Shifter empty too early");
    a_nine_bits: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        r.st == uart_tx_pkg::ST_DATA && bit_end && r.bit_cnt == 4'h7 && active
        |=> (r.st == uart_tx_pkg::ST_DATA) == $past(r.tx_ctl[`TS_NINE_BIT]))
        else $error("Wrong data bit count");
    a_stop_high: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        r.st == uart_tx_pkg::ST_STOP |-> r.line)
        else $error("Stop bit not high");
    a_irq_gate: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        !r.flag || !r.irq_ctl[`IC_GLOBAL_IRQ_ON] |-> !TX_IRQ)
        else $error("Interrupt without flag and enables");
    a_polarity: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        !active && $past(!active) |-> TX_OUT != r.baud_ctl[`BC_POLARITY_INVERT])
        else $error("Idle level wrong for polarity");

    a_start_low: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        r.st == uart_tx_pkg::ST_START |-> !r.line)
        else $error("Start bit not low");
    a_idle_line: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        r.st == uart_tx_pkg::ST_IDLE |-> r.line)
        else $error("Line not high while idle");
    a_data_lsb: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        r.st == uart_tx_pkg::ST_DATA |-> r.line == r.shift[0])
        else $error("Data bit not taken from shifter bottom");
    a_start_data: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        s_start_end |=> s_data_entry)
        else $error("Data did not follow start bit");
    a_bit_hold: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        r.st != uart_tx_pkg::ST_IDLE && !bit_end && active
        |=> r.st == $past(r.st) && r.line == $past(r.line))
        else $error("Bit changed before period end");
    a_queue_wait: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        s_queued |=> r.hold_full)
        else $error("Queued character lost before stop");
    a_full_drop: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        s_full_write |=> r.hold == $past(r.hold))
        else $error("Write over queued character");
    a_off_drop: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        !active |=> !r.hold_full)
        else $error("Queued character kept while off");
    a_flag_off: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        !active |=> !r.flag)
        else $error("Flag set while transmitter off");
    a_irq_raise: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        r.flag && r.irq_ctl[`IC_TX_IRQ_ON] && r.irq_ctl[`IC_PERIPH_IRQ_ON]
        && r.irq_ctl[`IC_GLOBAL_IRQ_ON] |-> TX_IRQ)
        else $error("Interrupt missing with flag and enables");
    a_port_off: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        !r.rx_ctl[`RS_PORT_ON] |-> !TX_OE)
        else $error("Transmit pin driven with port off");
    a_nine_capture: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        hold_acc |=> r.hold_full && r.hold9 == $past(r.tx_ctl[`TS_NINTH_DATA]))
        else $error("Ninth bit not captured with write");
    a_load_shift: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        load |=> r.shift[7:0] == $past(r.hold) && r.shift[8] == $past(r.hold9))
        else $error("Shifter not loaded from holding");
    a_status_read: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        PSEL && !PENABLE && PADDR == `OFS_TX_STATUS_CTRL
        |=> PRDATA[`TS_SHIFTER_EMPTY] == ($past(r.st) == uart_tx_pkg::ST_IDLE))
        else $error("Shifter-empty status misread");
endmodule
`default_nettype wire

/* shared/uart_tx_defs.svh */
// Register offsets, field positions and reset values of the serial transmitter
`ifndef UART_TX_DEFS_SVH
`define UART_TX_DEFS_SVH
// ****************
// Offsets
// ****************
`define OFS_BAUD_CONTROL     8'h00
`define OFS_RX_STATUS_CTRL   8'h04
`define OFS_DIVISOR_LOW      8'h08
`define OFS_DIVISOR_HIGH     8'h0c
`define OFS_TX_HOLDING       8'h10
`define OFS_TX_STATUS_CTRL   8'h14
`define OFS_IRQ_CONTROL      8'h18
// ****************
// Fields
// ****************
`define BC_POLARITY_INVERT   4
`define BC_WIDE_DIVISOR      3
`define RS_PORT_ON           7
`define TS_NINE_BIT          6
`define TS_TRANSMITTER_ON    5
`define TS_SYNC_MODE         4
`define TS_HIGH_SPEED        2
`define TS_SHIFTER_EMPTY     1
`define TS_NINTH_DATA        0
`define IC_TX_IRQ_ON         0
`define IC_PERIPH_IRQ_ON     1
`define IC_GLOBAL_IRQ_ON     2
`define IC_BUFFER_EMPTY      4
`define IC_WRITE_MASK        8'h07
// ****************
// Reset values and timing
// ****************
`define REG_RESET            8'h00
`define MULT_SLOW            24'd64
`define MULT_MID             24'd16
`define MULT_FAST            24'd4
`define LAST_BIT_EIGHT       4'd7
`define LAST_BIT_NINE        4'd8
`endif

/* shared/uart_tx_pkg.sv */
// Types of the serial transmitter
`default_nettype none
package uart_tx_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_DATA  = 2'b11,
        ST_STOP  = 2'b10
    } tx_state_t;

    typedef struct packed {
        logic [7:0]  baud_ctl;
        logic [7:0]  rx_ctl;
        logic [7:0]  div_lo;
        logic [7:0]  div_hi;
        logic [7:0]  tx_ctl;
        logic [7:0]  irq_ctl;
        logic [7:0]  hold;
        logic        hold9;
        logic        hold_full;
        tx_state_t   st;
        logic [8:0]  shift;
        logic [3:0]  bit_cnt;
        logic [23:0] baud_cnt;
        logic        flag;
        logic        line;
        logic [31:0] prdata;
    } tx_regs_t;
endpackage
`default_nettype wire

/* test/async_serial_transmitter_tb_top.sv */
// Register-level testbench of the serial transmitter with a line receiver
`default_nettype none
`include "uart_tx_defs.svh"
module async_serial_transmitter_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tx_out;
    logic        tx_oe;
    logic        tx_irq;
    logic        inv = 1'b0;
    logic        nine = 1'b0;
    logic [8:0]  rx_data;
    logic [7:0]  rx_frames;
    logic        rx_err;
    logic [31:0] rd;
    logic        er;
    int          fails = 0;
    int          comparisons = 0;
    int          k;
    always #2 clock = ~clock;
    async_serial_transmitter u_async_serial_transmitter (.CLOCK(clock), .RESET_N(reset_n),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TX_OUT(tx_out),
        .TX_OE(tx_oe), .TX_IRQ(tx_irq));
    serial_line_receiver u_serial_line_receiver (.clock(clock), .line(tx_out), .invert(inv),
        .nine(nine), .period(8'd4), .data(rx_data), .frames(rx_frames), .frame_err(rx_err));
    // ****************
    // Tasks
    // ****************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, then one idle edge so no strobe is assigned twice at once
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    task automatic frame(input logic [7:0] n, input logic [8:0] exp);
        k = 0;
        while (rx_frames !== n && k < 2000) begin
            @(posedge clock);
            k++;
        end
        check({24'h0, rx_frames}, {24'h0, n});
        check({23'h0, rx_data}, {23'h0, exp});
        check({31'h0, rx_err}, 32'h0);
    endtask
    task automatic stop_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ****************
    // Tests
    // ****************
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        stop_test();
    end
    initial begin
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        for (int a = 0; a < 7; a++) rdchk(8'(a * 4), (a == 5) ? 32'h2 : 32'h0);
        check({29'h0, pready, tx_oe, tx_out}, 32'h5);
        apb(1'b0, 8'h1c, 32'h0);
        check({31'h0, er}, 32'h1);
        apb(1'b1, `OFS_TX_HOLDING, 32'h55);
        repeat (60) @(posedge clock);
        check({24'h0, rx_frames}, 32'h0);
        apb(1'b1, `OFS_DIVISOR_LOW, 32'h0);
        apb(1'b1, `OFS_DIVISOR_HIGH, 32'h0);
        apb(1'b1, `OFS_BAUD_CONTROL, 32'h08);
        apb(1'b1, `OFS_RX_STATUS_CTRL, 32'h80);
        check({31'h0, tx_oe}, 32'h1);
        apb(1'b1, `OFS_TX_STATUS_CTRL, 32'h24);
        rdchk(`OFS_IRQ_CONTROL, 32'h10);
        apb(1'b1, `OFS_IRQ_CONTROL, 32'h03);
        rdchk(`OFS_IRQ_CONTROL, 32'h13);
        check({31'h0, tx_irq}, 32'h0);
        apb(1'b1, `OFS_IRQ_CONTROL, 32'h07);
        check({31'h0, tx_irq}, 32'h1);
        apb(1'b1, `OFS_TX_HOLDING, 32'ha5);
        rdchk(`OFS_TX_STATUS_CTRL, 32'h24);
        apb(1'b1, `OFS_TX_HOLDING, 32'h3c);
        @(posedge clock);
        rdchk(`OFS_IRQ_CONTROL, 32'h07);
        check({31'h0, tx_irq}, 32'h0);
        apb(1'b1, `OFS_IRQ_CONTROL, 32'h06);
        frame(8'h01, 9'h0a5);
        frame(8'h02, 9'h03c);
        repeat (8) @(posedge clock);
        rdchk(`OFS_TX_STATUS_CTRL, 32'h26);
        rdchk(`OFS_IRQ_CONTROL, 32'h16);
        check({31'h0, tx_irq}, 32'h0);
        nine <= 1'b1;
        apb(1'b1, `OFS_TX_STATUS_CTRL, 32'h65);
        apb(1'b1, `OFS_TX_HOLDING, 32'h12);
        frame(8'h03, 9'h112);
        repeat (8) @(posedge clock);
        inv <= 1'b1;
        apb(1'b1, `OFS_BAUD_CONTROL, 32'h18);
        check({31'h0, tx_out}, 32'h0);
        apb(1'b1, `OFS_TX_HOLDING, 32'h5a);
        frame(8'h04, 9'h15a);
        repeat (8) @(posedge clock);
        apb(1'b1, `OFS_TX_STATUS_CTRL, 32'h04);
        rdchk(`OFS_IRQ_CONTROL, 32'h06);
        stop_test();
    end
endmodule
`default_nettype wire

/* test/serial_line_receiver.sv */
// Behavioural remote receiver that decodes frames seen on the transmit line
`default_nettype none
module serial_line_receiver (
    input  wire logic       clock,
    input  wire logic       line,
    input  wire logic       invert,
    input  wire logic       nine,
    input  wire logic [7:0] period,
    output logic      [8:0] data,
    output logic      [7:0] frames,
    output logic            frame_err
);
    timeunit 1ns;
    timeprecision 1ps;
    int i;
    // Samples on the falling edge so the line has settled after the rising edge
    initial begin
        data = 9'h000;
        frames = 8'h00;
        frame_err = 1'b0;
        forever begin
            @(negedge clock);
            if ((line ^ invert) === 1'b0) begin
                repeat (period / 2) @(negedge clock);
                // A start level gone by mid-bit is a glitch, not a frame
                if ((line ^ invert) === 1'b0) begin
                    data = 9'h000;
                    for (i = 0; i < (nine ? 9 : 8); i++) begin
                        repeat (period) @(negedge clock);
                        data[i] = line ^ invert;
                    end
                    repeat (period) @(negedge clock);
                    if ((line ^ invert) !== 1'b1) frame_err = 1'b1;
                    frames = frames + 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire
